/* File: logic/synth_ctrl_pkg.sv */
// Constants and carrier types for the synthesizer control logic
package synth_ctrl_pkg;
  // Serial word and latch selection
  localparam int WORD_W = 24;
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_REF = 2'h1;
  localparam logic [1:0] SEL_FB = 2'h2;
  localparam logic [1:0] SEL_TEST = 2'h3;
  localparam logic [23:0] LATCH_RST = 24'h00_0000;
  // Control latch fields
  localparam int C_PRE_LSB = 22;
  localparam int C_PD1_BIT = 20;
  localparam int C_MUTE_UNTIL_LOCK_BIT = 11;
  localparam int C_MON_LSB = 5;
  // Reference latch fields
  localparam int R_BSC_LSB = 20;
  localparam int R_LDP_BIT = 18;
  localparam int R_ABP_LSB = 16;
  localparam int R_DIV_LSB = 2;
  // Feedback latch fields
  localparam int F_HALF_BIT = 22;
  localparam int F_B_LSB = 8;
  localparam int F_A_LSB = 2;
  // Monitor selections
  localparam logic [2:0] MON_DLOCK = 3'h1;
  localparam logic [2:0] MON_FBDIV = 3'h2;
  localparam logic [2:0] MON_HIGH = 3'h3;
  localparam logic [2:0] MON_REFDIV = 3'h4;
  localparam logic [2:0] MON_ALOCK = 3'h5;
  localparam logic [2:0] MON_SDATA = 3'h6;
  // Timing
  localparam int PCLK_PERIOD_NS = 20;
  localparam int LOCK_ERR_NS = 15;
  localparam int UNLOCK_ERR_NS = 25;
  localparam int LOCK_CYC_LO = 3;
  localparam int LOCK_CYC_HI = 5;
  localparam int BAND_PD_CYC = 5;
  localparam int ABP_BASE_CYC = 1;
  // APB map
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_REF = 8'h04;
  localparam logic [7:0] A_FB = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_CFG = 8'h10;
  localparam logic CFG_RST = 1'h1;
  typedef struct packed {
    logic band_busy;
    logic dig_lock;
    logic powered;
  } status_t;
endpackage

/* File: logic/synth_ctrl.sv */
// Synthesizer digital control: serial latches, dividers, lock detect, band select
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module synth_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Three-wire serial link
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  // Reference and prescaler inputs, chip enable
  input wire logic ref_in,
  input wire logic prescaler_in,
  input wire logic chip_enable,
  // Phase detector and analog controls
  output logic pd_up,
  output logic pd_down,
  output logic cp_tristate,
  output logic vtune_on_ref,
  output logic rf_stage_on,
  output logic half_output_divide,
  output logic core_powered,
  // Monitor pin, open drain in analog lock mode
  output logic monitor_output_pin,
  output logic monitor_oe
);
  logic [23:0] shift_q, ctrl_q, ref_q, fb_q;
  logic sclk_q, load_q, refin_q, pre_q, serial_en_q;
  logic [13:0] ref_cnt_q;
  logic [18:0] fb_cnt_q;
  logic ref_pend_q, fb_pend_q;
  logic [7:0] err_q;
  logic [2:0] good_cnt_q;
  logic dig_lock_q;
  logic [2:0] abp_cnt_q;
  logic [2:0] bdiv_q;
  logic [2:0] band_cnt_q;
  logic band_busy_q;
  logic mon_q, mon_oe_q, up_q, dn_q, cpt_q, rfon_q, half_q, pwr_q, vtref_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;

  // Serial edge detection; pins are synchronous to pclk
  wire sclk_rise = serial_clk & ~sclk_q;
  wire ld_rise = load_strobe & ~load_q & serial_en_q;
  wire [1:0] ld_sel = shift_q[1:0];
  wire ld_ctrl = ld_rise && ld_sel == synth_ctrl_pkg::SEL_CTRL;
  wire ld_ref = ld_rise && ld_sel == synth_ctrl_pkg::SEL_REF;
  wire ld_fb = ld_rise && ld_sel == synth_ctrl_pkg::SEL_FB;

  // Field decode
  wire [1:0] pre_sel = ctrl_q[synth_ctrl_pkg::C_PRE_LSB +: 2];
  wire [2:0] mon_sel = ctrl_q[synth_ctrl_pkg::C_MON_LSB +: 3];
  wire mute_until_lock = ctrl_q[synth_ctrl_pkg::C_MUTE_UNTIL_LOCK_BIT];
  wire [13:0] r_div = ref_q[synth_ctrl_pkg::R_DIV_LSB +: 14];
  wire [1:0] abp_sel = ref_q[synth_ctrl_pkg::R_ABP_LSB +: 2];
  wire lock_precision = ref_q[synth_ctrl_pkg::R_LDP_BIT];
  wire [1:0] bsc = ref_q[synth_ctrl_pkg::R_BSC_LSB +: 2];
  wire [12:0] b_div = fb_q[synth_ctrl_pkg::F_B_LSB +: 13];
  wire [4:0] a_div = fb_q[synth_ctrl_pkg::F_A_LSB +: 5];

  // Prescaler modulus; code 3 also gives 32
  wire [5:0] p_mod = (pre_sel == 2'h0) ? 6'h08 : (pre_sel == 2'h1) ? 6'h10 : 6'h20;
  wire [18:0] n_ratio = 19'(b_div * p_mod) + 19'(a_div);
  wire [18:0] n_lim = (n_ratio == 19'h0_0000) ? 19'h0_0000 : n_ratio - 19'h0_0001;
  wire [13:0] r_lim = (r_div == 14'h0000) ? 14'h0000 : r_div - 14'h0001;

  // Divider ticks; counts edges of the sampled reference and prescaler inputs
  wire ref_edge = ref_in & ~refin_q;
  wire pre_edge = prescaler_in & ~pre_q;
  wire ref_tick = ref_edge && ref_cnt_q >= r_lim;
  wire fb_tick = pre_edge && fb_cnt_q >= n_lim;

  // Phase error in pclk cycles, known when the later of the two ticks arrives
  wire idle_pd = ~ref_pend_q & ~fb_pend_q;
  wire both_now = ref_tick & fb_tick & idle_pd;
  wire pd_done = both_now | (ref_pend_q & fb_tick) | (fb_pend_q & ref_tick);
  wire [7:0] err_now = both_now ? 8'h00 : err_q;
  wire [15:0] err_ns = 16'(err_now) * 16'(synth_ctrl_pkg::PCLK_PERIOD_NS);
  wire err_good = pd_done && err_ns < 16'(synth_ctrl_pkg::LOCK_ERR_NS);
  wire err_bad = pd_done && err_ns > 16'(synth_ctrl_pkg::UNLOCK_ERR_NS);
  wire [2:0] lock_need = lock_precision ? 3'(synth_ctrl_pkg::LOCK_CYC_HI)
                             : 3'(synth_ctrl_pkg::LOCK_CYC_LO);

  // Band clock divider mask: 1, 2, 4 or 8
  wire [2:0] bmask = 3'((4'h1 << bsc) - 4'h1);
  wire band_tick = ref_tick && (bdiv_q & bmask) == bmask;

  // APB decode
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready_q & pwrite;
  wire a_hit = paddr == synth_ctrl_pkg::A_CTRL || paddr == synth_ctrl_pkg::A_REF
            || paddr == synth_ctrl_pkg::A_FB || paddr == synth_ctrl_pkg::A_STAT
            || paddr == synth_ctrl_pkg::A_CFG;
  synth_ctrl_pkg::status_t stat;
  assign stat = '{band_busy: band_busy_q, dig_lock: dig_lock_q, powered: pwr_q};
  wire [31:0] rd_mux = (paddr == synth_ctrl_pkg::A_CTRL) ? {8'h00, ctrl_q}
                     : (paddr == synth_ctrl_pkg::A_REF) ? {8'h00, ref_q}
                     : (paddr == synth_ctrl_pkg::A_FB) ? {8'h00, fb_q}
                     : (paddr == synth_ctrl_pkg::A_STAT) ? {29'h0000_0000, stat}
                     : (paddr == synth_ctrl_pkg::A_CFG) ? {31'h0000_0000, serial_en_q}
                     : 32'h0000_0000;

  // Monitor selection; analog lock drives low only while the detector pulses differ
  wire alock_low = up_q ^ dn_q;
  wire mon_d = (mon_sel == synth_ctrl_pkg::MON_DLOCK) ? dig_lock_q
             : (mon_sel == synth_ctrl_pkg::MON_FBDIV) ? fb_tick
             : (mon_sel == synth_ctrl_pkg::MON_HIGH) ? 1'b1
             : (mon_sel == synth_ctrl_pkg::MON_REFDIV) ? ref_tick
             : (mon_sel == synth_ctrl_pkg::MON_SDATA) ? shift_q[23]
             : 1'b0;
  wire is_alock = mon_sel == synth_ctrl_pkg::MON_ALOCK;

  // Serial shift register and pin edge-detect flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_q <= synth_ctrl_pkg::LATCH_RST;
      sclk_q <= 1'b0;
      load_q <= 1'b0;
    end
    else
    begin
      sclk_q <= serial_clk;
      load_q <= load_strobe;
      if (sclk_rise)
        shift_q <= {shift_q[22:0], serial_data};
    end
  end

  // Test latch words are dropped; other latches change only on their own load
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= synth_ctrl_pkg::LATCH_RST;
      ref_q <= synth_ctrl_pkg::LATCH_RST;
      fb_q <= synth_ctrl_pkg::LATCH_RST;
    end
    else
    begin
      if (ld_ctrl)
        ctrl_q <= shift_q;
      if (ld_ref)
        ref_q <= shift_q;
      if (ld_fb)
        fb_q <= shift_q;
    end
  end

  // Reference and feedback dividers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      refin_q <= 1'b0;
      pre_q <= 1'b0;
      ref_cnt_q <= 14'h0000;
      fb_cnt_q <= 19'h0_0000;
    end
    else
    begin
      refin_q <= ref_in;
      pre_q <= prescaler_in;
      if (ref_edge)
        ref_cnt_q <= ref_tick ? 14'h0000 : ref_cnt_q + 14'h0001;
      if (pre_edge)
        fb_cnt_q <= fb_tick ? 19'h0_0000 : fb_cnt_q + 19'h0_0001;
    end
  end

  // Phase error measurement and digital lock detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_pend_q <= 1'b0;
      fb_pend_q <= 1'b0;
      err_q <= 8'h00;
      good_cnt_q <= 3'h0;
      dig_lock_q <= 1'b0;
    end
    else
    begin
      if (pd_done)
      begin
        ref_pend_q <= 1'b0;
        fb_pend_q <= 1'b0;
        err_q <= 8'h00;
      end
      else if (idle_pd)
      begin
        ref_pend_q <= ref_tick;
        fb_pend_q <= fb_tick;
        err_q <= {7'h00, ref_tick | fb_tick};
      end
      else if (err_q != 8'hFF)
        err_q <= err_q + 8'h01;
      if (pd_done)
        good_cnt_q <= !err_good ? 3'h0 : (good_cnt_q == lock_need) ? good_cnt_q
                    : good_cnt_q + 3'h1;
      if (err_bad)
        dig_lock_q <= 1'b0;
      else if (err_good && good_cnt_q + 3'h1 >= lock_need)
        dig_lock_q <= 1'b1;
    end
  end

  // Up and down pulses reset together after the antibacklash delay
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
      abp_cnt_q <= 3'h0;
    end
    else if (up_q && dn_q)
    begin
      abp_cnt_q <= abp_cnt_q + 3'h1;
      if (abp_cnt_q >= 3'(abp_sel) + 3'(synth_ctrl_pkg::ABP_BASE_CYC) - 3'h1)
      begin
        up_q <= 1'b0;
        dn_q <= 1'b0;
        abp_cnt_q <= 3'h0;
      end
    end
    else
    begin
      up_q <= up_q | ref_tick;
      dn_q <= dn_q | fb_tick;
    end
  end

  // Band selection: busy from power-up, restarted by every feedback load
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bdiv_q <= 3'h0;
      band_cnt_q <= 3'h0;
      band_busy_q <= 1'b1;
    end
    else
    begin
      if (ref_tick)
        bdiv_q <= bdiv_q + 3'h1;
      if (ld_fb)
      begin
        band_busy_q <= 1'b1;
        band_cnt_q <= 3'h0;
      end
      else if (band_busy_q && band_tick)
      begin
        band_cnt_q <= band_cnt_q + 3'h1;
        if (band_cnt_q == 3'(synth_ctrl_pkg::BAND_PD_CYC - 1))
        begin
          band_busy_q <= 1'b0;
          band_cnt_q <= 3'h0;
        end
      end
    end
  end

  // Output stage, power and monitor flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mon_q <= 1'b0;
      mon_oe_q <= 1'b0;
      cpt_q <= 1'b1;
      rfon_q <= 1'b0;
      half_q <= 1'b0;
      pwr_q <= 1'b0;
      vtref_q <= 1'b0;
    end
    else
    begin
      mon_q <= is_alock ? 1'b0 : mon_d;
      mon_oe_q <= is_alock ? alock_low : 1'b1;
      cpt_q <= ~chip_enable;
      pwr_q <= chip_enable & ~ctrl_q[synth_ctrl_pkg::C_PD1_BIT];
      rfon_q <= pwr_q & ~(mute_until_lock & ~dig_lock_q);
      half_q <= fb_q[synth_ctrl_pkg::F_HALF_BIT];
      vtref_q <= band_busy_q;
    end
  end

  // APB slave: no wait states, data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      serial_en_q <= synth_ctrl_pkg::CFG_RST;
    end
    else
    begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup & ~a_hit;
      if (apb_setup)
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      if (apb_wr && paddr == synth_ctrl_pkg::A_CFG)
        serial_en_q <= pwdata[0];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pd_up = up_q;
  assign pd_down = dn_q;
  assign cp_tristate = cpt_q;
  assign vtune_on_ref = vtref_q;
  assign rf_stage_on = rfon_q;
  assign half_output_divide = half_q;
  assign core_powered = pwr_q;
  assign monitor_output_pin = mon_q;
  assign monitor_oe = mon_oe_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_shift_msb_first: assert property (sclk_rise |=> shift_q[0] == $past(serial_data))
    else $error("serial bit not shifted in");
  a_test_latch_drop: assert property (ld_rise && ld_sel == synth_ctrl_pkg::SEL_TEST
      |=> $stable(ctrl_q) && $stable(ref_q) && $stable(fb_q))
    else $error("test latch word changed a latch");
  a_latch_hold: assert property (!ld_rise |=> $stable(ctrl_q) && $stable(ref_q) && $stable(fb_q))
    else $error("latch changed without load strobe");
  a_lock_clear: assert property (err_bad |=> !dig_lock_q)
    else $error("lock held after large phase error");
  a_lock_early: assert property (!dig_lock_q && pd_done && good_cnt_q + 3'h1 < lock_need
      |=> !dig_lock_q)
    else $error("lock set too early");
  a_band_window: assert property (ld_fb |=> band_busy_q ##1 vtune_on_ref)
    else $error("band select not started by feedback load");
  a_mute_lock: assert property (mute_until_lock && !dig_lock_q |=> !rf_stage_on)
    else $error("rf stage on before lock");
  a_ce_tristate: assert property (!chip_enable |=> cp_tristate)
    else $error("charge pump not three-stated");
  a_mon_lock: assert property (mon_sel == synth_ctrl_pkg::MON_DLOCK
      |=> monitor_output_pin == $past(dig_lock_q) && monitor_oe)
    else $error("monitor does not show lock");
  a_alock_drive: assert property (is_alock
      |=> !monitor_output_pin && monitor_oe == $past(up_q ^ dn_q))
    else $error("analog lock pin not open drain");
  a_abp_release: assert property (up_q && dn_q && abp_sel == 2'h0
      |=> !pd_up && !pd_down)
    else $error("antibacklash pulse too long");
endmodule

/* File: verif/serial_host.sv */
// Host model driving the three-wire programming link one word at a time
`timescale 1ns/1ps
module serial_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request from the bench
  input wire logic [23:0] word,
  input wire logic go,
  output logic busy,
  // Three-wire link
  output logic serial_clk,
  output logic serial_data,
  output logic load_strobe
);
  logic [23:0] sh_q;
  logic [4:0] left_q;
  logic [1:0] ph_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy <= 1'b0;
      serial_clk <= 1'b0;
      serial_data <= 1'b0;
      load_strobe <= 1'b0;
    end
    else if (!busy)
    begin
      if (go)
      begin
        busy <= 1'b1;
        sh_q <= word;
        left_q <= 5'h18;
        ph_q <= 2'h0;
      end
    end
    else
    begin
      ph_q <= ph_q + 2'h1;
      case (ph_q)
        2'h0:
        begin
          if (left_q == 5'h00)
            load_strobe <= 1'b1;
          else
            serial_data <= sh_q[23];
        end
        2'h1: serial_clk <= (left_q != 5'h00);
        2'h2: serial_clk <= 1'b0;
        default:
        begin
          // Data line turns over once its hold ends so a stale bit is never read
          serial_data <= ~serial_data;
          sh_q <= {sh_q[22:0], 1'b0};
          if (left_q == 5'h00)
          begin
            load_strobe <= 1'b0;
            busy <= 1'b0;
          end
          else
            left_q <= left_q - 5'h01;
        end
      endcase
    end
  end
endmodule

/* File: verif/synth_divider_control_logic_test.sv */
// Bench for the synthesizer control block: link, APB readback, band select, lock
`timescale 1ns/1ps
module synth_divider_control_logic_test;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic serial_clk, serial_data, load_strobe;
  logic ref_in = 0;
  logic prescaler_in = 0;
  logic chip_enable = 1;
  logic pd_up, pd_down, cp_tristate, vtune_on_ref, rf_stage_on;
  logic half_output_divide, core_powered, monitor_output_pin, monitor_oe;
  logic [23:0] word = 24'h00_0000;
  logic go = 0;
  logic busy;
  logic [31:0] rd;
  logic er;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int vt_cnt = 0;
  int vt0 = 0;
  logic ph = 0;

  always #10 pclk = ~pclk;

  synth_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_clk(serial_clk), .serial_data(serial_data),
    .load_strobe(load_strobe), .ref_in(ref_in), .prescaler_in(prescaler_in),
    .chip_enable(chip_enable), .pd_up(pd_up), .pd_down(pd_down), .cp_tristate(cp_tristate),
    .vtune_on_ref(vtune_on_ref), .rf_stage_on(rf_stage_on),
    .half_output_divide(half_output_divide), .core_powered(core_powered),
    .monitor_output_pin(monitor_output_pin), .monitor_oe(monitor_oe));

  serial_host host (.pclk(pclk), .presetn(presetn), .word(word), .go(go), .busy(busy),
    .serial_clk(serial_clk), .serial_data(serial_data), .load_strobe(load_strobe));

  // Reference and VCO share one edge train; whichever divider ticked first pauses
  // until the other ticks, so the loop pulls into phase as a real loop would
  always @(posedge pclk)
  begin
    ph <= ~ph;
    ref_in <= (pd_up === 1'b1 && pd_down !== 1'b1) ? 1'b0 : ~ph;
    prescaler_in <= (pd_down === 1'b1 && pd_up !== 1'b1) ? 1'b0 : ~ph;
    if (vtune_on_ref === 1'b1)
      vt_cnt <= vt_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  task final_report;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task send(input logic [23:0] w);
    @(posedge pclk);
    word <= w;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    do @(posedge pclk); while (busy === 1'b1);
    repeat (3) @(posedge pclk);
  endtask

  task wait_stat(input int b, input logic v);
    for (int i = 0; i < 1500; i++)
    begin
      apb(1'b0, synth_ctrl_pkg::A_STAT, 32'h0000_0000);
      if (rd[b] === v)
        break;
    end
  endtask

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, synth_ctrl_pkg::A_CFG, 32'h0000_0000);
    chk("cfg", rd, 32'h0000_0001);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped err", {31'h0, er}, 32'h0000_0001);
    apb(1'b1, synth_ctrl_pkg::A_CTRL, 32'h00FF_FFFF);
    apb(1'b0, synth_ctrl_pkg::A_CTRL, 32'h0000_0000);
    chk("ctrl ro", rd, 32'h0000_0000);
    // Deliberate test-latch word; the design must drop it
    send(24'h12_3457);
    apb(1'b0, synth_ctrl_pkg::A_REF, 32'h0000_0000);
    chk("test word dropped", rd, 32'h0000_0000);
    send(24'h00_00E1);
    send(24'h00_0820);
    vt0 = vt_cnt;
    send(24'h40_0702);
    chk("band busy vtune", {31'h0, vtune_on_ref}, 32'h0000_0001);
    chk("muted before lock", {31'h0, rf_stage_on}, 32'h0000_0000);
    apb(1'b0, synth_ctrl_pkg::A_REF, 32'h0000_0000);
    chk("ref latch", rd, 32'h0000_00E1);
    apb(1'b0, synth_ctrl_pkg::A_CTRL, 32'h0000_0000);
    chk("ctrl latch", rd, 32'h0000_0820);
    apb(1'b0, synth_ctrl_pkg::A_FB, 32'h0000_0000);
    chk("fb latch", rd, 32'h0040_0702);
    chk("half divide", {31'h0, half_output_divide}, 32'h0000_0001);
    wait_stat(2, 1'b0);
    chk("band done", {31'h0, rd[2]}, 32'h0000_0000);
    // Five band ticks of 112 cycles each, one tick of slack for phase
    chk("band length", {31'h0, vt_cnt - vt0 >= 448 && vt_cnt - vt0 <= 560},
      32'h0000_0001);
    wait_stat(1, 1'b1);
    chk("locked", {31'h0, rd[1]}, 32'h0000_0001);
    chk("monitor lock", {31'h0, monitor_output_pin}, 32'h0000_0001);
    chk("unmuted", {31'h0, rf_stage_on}, 32'h0000_0001);
    send(24'h00_00DD);
    wait_stat(1, 1'b0);
    chk("unlocked", {31'h0, rd[1]}, 32'h0000_0000);
    chip_enable <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("cp tristate", {31'h0, cp_tristate}, 32'h0000_0001);
    chk("core off", {31'h0, core_powered}, 32'h0000_0000);
    chip_enable <= 1'b1;
    apb(1'b1, synth_ctrl_pkg::A_CFG, 32'h0000_0000);
    send(24'h00_0060);
    apb(1'b0, synth_ctrl_pkg::A_CTRL, 32'h0000_0000);
    chk("load blocked", rd, 32'h0000_0820);
    apb(1'b1, synth_ctrl_pkg::A_CFG, 32'h0000_0001);
    send(24'h00_0060);
    chk("monitor high", {31'h0, monitor_output_pin}, 32'h0000_0001);
    send(24'h00_0000);
    chk("monitor low", {31'h0, monitor_output_pin}, 32'h0000_0000);
    // Relock, then the open-drain lock pin must be released
    send(24'h00_00E1);
    send(24'h00_00A0);
    wait_stat(1, 1'b1);
    chk("alock oe", {31'h0, monitor_oe}, 32'h0000_0000);
    chk("alock pin", {31'h0, monitor_output_pin}, 32'h0000_0000);
    final_report();
  end
endmodule
